// ### rtl/ifca_map.svh
/*
 * Register map, field positions, reset values and encodings of the
 * indirect fabric register access port.
 * Assumes it is included by its bare name from the rtl folder.
 */
`ifndef IFCA_MAP_SVH
`define IFCA_MAP_SVH

// ----------------------------------------------------------------------------
// Host register offsets (byte addresses on APB)
// ----------------------------------------------------------------------------
`define IFCA_DATA_OFS 12'h1AC
`define IFCA_CMD_OFS 12'h1B0

// ----------------------------------------------------------------------------
// Command register fields
// ----------------------------------------------------------------------------
`define IFCA_BUSY_BIT 31
`define IFCA_DIR_BIT 30
`define IFCA_INC_BIT 29
`define IFCA_DEC_BIT 28
`define IFCA_BE_MSB 19
`define IFCA_BE_LSB 16
`define IFCA_ADDR_MSB 15
`define IFCA_ADDR_LSB 0
`define IFCA_RSVD_W 8

// ----------------------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------------------
`define IFCA_DATA_RST 32'h0000_0000
`define IFCA_BE_RST 4'h0
`define IFCA_ADDR_RST 16'h0000
`define IFCA_DIR_WRITE 1'b0
`define IFCA_DIR_READ 1'b1
`define IFCA_STEP 16'h0001

`endif

// ### rtl/ifca_pkg.sv
/*
 * Types shared by both ends of the indirect fabric register access port.
 * Assumes nothing of its surroundings.
 */
package ifca_pkg;

    // ------------------------------------------------------------------------
    // Host-side bridge state
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        IFCA_BR_IDLE = 2'b01,
        IFCA_BR_WAIT = 2'b10
    } ifca_br_state_t;

    typedef struct packed {
        ifca_br_state_t state;
        logic busy;
        logic dir;
        logic inc;
        logic dec;
        logic [3:0] be;
        logic [15:0] addr;
        logic [31:0] wr_data;
        logic [31:0] rd_data;
        logic step_after;
        logic req;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ifca_br_st_t;

    // ------------------------------------------------------------------------
    // Fabric-side responder state
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        IFCA_FB_IDLE = 3'b001,
        IFCA_FB_FETCH = 3'b010,
        IFCA_FB_ACK = 3'b100
    } ifca_fb_state_t;

    typedef struct packed {
        ifca_fb_state_t state;
        logic [15:0] target_address;
        logic [31:0] csr_wdata;
        logic csr_wr;
        logic [31:0] rdata;
        logic ack;
    } ifca_fb_st_t;

endpackage

// ### rtl/ifca_link_if.sv
/*
 * Link between the host-side bridge and the fabric register logic.
 * Assumes both ends run on the same sys_clk; no clocking block is used.
 */
`timescale 1ns/1ps

interface ifca_link_if;
    logic req;
    logic dir;
    logic [15:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic ack;

    modport bridge_mp (
        output req,
        output dir,
        output addr,
        output be,
        output wdata,
        input rdata,
        input ack
    );

    modport fabric_mp (
        input req,
        input dir,
        input addr,
        input be,
        input wdata,
        output rdata,
        output ack
    );
endinterface

// ### rtl/ifca_fabric_end.sv
/*
 * Fabric end of the indirect access link: turns one link request into a
 * read, or a byte-masked read-modify-write, of the fabric register storage.
 * Assumes the storage answers csr_rdata combinationally for target_address on the
 * same sys_clk, and takes csr_wdata when csr_wr is high at a rising edge.
 */
`timescale 1ns/1ps

module ifca_fabric_end (
    input wire logic sys_clk,
    input wire logic nrst,
    ifca_link_if.fabric_mp link,
    output logic [15:0] target_address,
    output logic [31:0] csr_wdata,
    output logic csr_wr,
    input wire logic [31:0] csr_rdata
);
    import ifca_pkg::*;
    `include "ifca_map.svh"

    localparam ifca_fb_st_t RST_ST = '{
        state: IFCA_FB_IDLE,
        target_address: `IFCA_ADDR_RST,
        csr_wdata: `IFCA_DATA_RST,
        csr_wr: 1'b0,
        rdata: `IFCA_DATA_RST,
        ack: 1'b0
    };

    ifca_fb_st_t st_ff;
    ifca_fb_st_t nxt_st;
    logic [31:0] lane_mask;

    // ------------------------------------------------------------------------
    // Byte lane mask
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign lane_mask[gi*8 +: 8] = {8{link.be[gi]}};
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Request handling
    // ------------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.csr_wr = 1'b0;
        case (st_ff.state)
            IFCA_FB_IDLE: begin
                if (link.req) begin
                    nxt_st.target_address = link.addr;
                    nxt_st.state = IFCA_FB_FETCH;
                end
            end
            IFCA_FB_FETCH: begin
                // Disabled lanes keep the old contents of the target.
                nxt_st.rdata = csr_rdata;
                nxt_st.csr_wdata = (csr_rdata & ~lane_mask) | (link.wdata & lane_mask);
                nxt_st.csr_wr = (link.dir == `IFCA_DIR_WRITE);
                nxt_st.ack = 1'b1;
                nxt_st.state = IFCA_FB_ACK;
            end
            IFCA_FB_ACK: begin
                nxt_st.ack = 1'b0;
                nxt_st.state = IFCA_FB_IDLE;
            end
            default: begin
                nxt_st = RST_ST;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            st_ff <= RST_ST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign link.rdata = st_ff.rdata;
    assign link.ack = st_ff.ack;
    assign target_address = st_ff.target_address;
    assign csr_wdata = st_ff.csr_wdata;
    assign csr_wr = st_ff.csr_wr;
endmodule

// ### rtl/ifca_bridge.sv
/*
 * Host end of the indirect fabric register access port: an APB slave that
 * holds the data and command registers and runs one fabric access per start.
 * Assumes an APB master on sys_clk and a fabric end on the link interface
 * that answers each request with a one-cycle ack.
 */
// Added by the designer: the APB slave port.
`timescale 1ns/1ps

module ifca_bridge #(
    parameter int APB_AW = 12
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    ifca_link_if.bridge_mp link
);
    import ifca_pkg::*;
    `include "ifca_map.svh"

    // ------------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------------
    generate
        if (APB_AW < 12) begin : g_bad_aw
            $error("APB_AW must be at least 12 to reach the register offsets");
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Reset state
    // ------------------------------------------------------------------------
    localparam ifca_br_st_t RST_ST = '{
        state: IFCA_BR_IDLE,
        busy: 1'b0,
        dir: `IFCA_DIR_WRITE,
        inc: 1'b0,
        dec: 1'b0,
        be: `IFCA_BE_RST,
        addr: `IFCA_ADDR_RST,
        wr_data: `IFCA_DATA_RST,
        rd_data: `IFCA_DATA_RST,
        step_after: 1'b0,
        req: 1'b0,
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: `IFCA_DATA_RST
    };

    ifca_br_st_t st_ff;
    ifca_br_st_t nxt_st;

    // ------------------------------------------------------------------------
    // Address decode and register views
    // ------------------------------------------------------------------------
    logic hit_data;
    logic hit_cmd;
    logic apb_setup;
    logic apb_access;
    logic auto_on;
    logic [31:0] cmd_word;
    logic [31:0] data_view;

    // Bits above the low twelve must be zero, so the registers never alias higher up.
    // A shift rather than a part-select keeps the decode legal at the minimum bus width.
    assign hit_data = (paddr[11:0] == `IFCA_DATA_OFS) && ((paddr >> 12) == '0);
    assign hit_cmd = (paddr[11:0] == `IFCA_CMD_OFS) && ((paddr >> 12) == '0);
    assign apb_setup = psel && !penable;
    assign apb_access = psel && penable && st_ff.pready;
    assign auto_on = st_ff.inc || st_ff.dec;
    assign cmd_word = {st_ff.busy, st_ff.dir, st_ff.inc, st_ff.dec, {`IFCA_RSVD_W{1'b0}}, st_ff.be, st_ff.addr};
    assign data_view = (st_ff.dir == `IFCA_DIR_READ) ? st_ff.rd_data : st_ff.wr_data;

    // ------------------------------------------------------------------------
    // Address stepping
    // ------------------------------------------------------------------------
    // Increment takes precedence when both stepping options are set.
    function automatic logic [15:0] step_addr(input logic [15:0] a, input logic up);
        logic [15:0] r;
        r = up ? (a + `IFCA_STEP) : (a - `IFCA_STEP);
        return r;
    endfunction

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------
    always_comb begin
        logic start;
        start = 1'b0;
        nxt_st = st_ff;
        nxt_st.pready = 1'b0;
        nxt_st.pslverr = 1'b0;

        // Read data is captured in the setup cycle so the slave never
        // stretches the access phase; every transfer ends on its first edge.
        if (apb_setup) begin
            nxt_st.pready = 1'b1;
            nxt_st.pslverr = !(hit_data || hit_cmd);
            if (hit_data) begin
                nxt_st.prdata = data_view;
            end else if (hit_cmd) begin
                nxt_st.prdata = cmd_word;
            end else begin
                nxt_st.prdata = `IFCA_DATA_RST;
            end
        end

        // Writes and stepping reads are ignored while busy, so a careless
        // host cannot corrupt the request held toward the fabric.
        if (apb_access && !st_ff.busy) begin
            if (pwrite && hit_cmd) begin
                nxt_st.dir = pwdata[`IFCA_DIR_BIT];
                nxt_st.inc = pwdata[`IFCA_INC_BIT];
                nxt_st.dec = pwdata[`IFCA_DEC_BIT];
                nxt_st.be = pwdata[`IFCA_BE_MSB:`IFCA_BE_LSB];
                nxt_st.addr = pwdata[`IFCA_ADDR_MSB:`IFCA_ADDR_LSB];
                nxt_st.step_after = 1'b0;
                start = pwdata[`IFCA_BUSY_BIT];
            end else if (pwrite && hit_data) begin
                nxt_st.wr_data = pwdata;
                if (auto_on) begin
                    nxt_st.step_after = 1'b1;
                    start = 1'b1;
                end
            end else if (!pwrite && hit_data && auto_on) begin
                nxt_st.addr = step_addr(st_ff.addr, st_ff.inc);
                nxt_st.step_after = 1'b0;
                start = 1'b1;
            end
        end

        case (st_ff.state)
            IFCA_BR_IDLE: begin
                if (start) begin
                    nxt_st.busy = 1'b1;
                    nxt_st.req = 1'b1;
                    nxt_st.state = IFCA_BR_WAIT;
                end
            end
            IFCA_BR_WAIT: begin
                if (link.ack) begin
                    nxt_st.req = 1'b0;
                    nxt_st.busy = 1'b0;
                    nxt_st.state = IFCA_BR_IDLE;
                    if (st_ff.dir == `IFCA_DIR_READ) begin
                        nxt_st.rd_data = link.rdata;
                    end
                    // The host sees the address of the finished write until busy clears.
                    if (st_ff.step_after) begin
                        nxt_st.addr = step_addr(st_ff.addr, st_ff.inc);
                        nxt_st.step_after = 1'b0;
                    end
                end
            end
            default: begin
                nxt_st = RST_ST;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            st_ff <= RST_ST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;
    assign link.req = st_ff.req;
    assign link.dir = st_ff.dir;
    assign link.addr = st_ff.addr;
    assign link.be = st_ff.be;
    assign link.wdata = st_ff.wr_data;
endmodule

// ### test/ifca_link_checker.sv
/*
 * Checker of the request link between the host bridge and the fabric end.
 * Assumes one sys_clk domain and a synchronous active-low nrst.
 */
`timescale 1ns/1ps

module ifca_link_checker (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic req,
    input wire logic dir,
    input wire logic [15:0] addr,
    input wire logic [3:0] be,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic ack
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // ------------------------------------------------------------------------
    // Link timing
    // ------------------------------------------------------------------------
    property p_ack_lat; $rose(req) |-> !ack ##1 !ack ##1 ack; endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("ack not two cycles after request");
    property p_req_len; $rose(req) |-> req [*3] ##1 !req; endproperty
    a_req_len: assert property (p_req_len) else $error("request not held to its ack");
    property p_hold; req && !ack |=> $stable({dir, addr, be, wdata}); endproperty
    a_hold: assert property (p_hold) else $error("request fields moved before ack");
    property p_ack_pulse; ack |=> !ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_req; ack |-> req; endproperty
    a_ack_req: assert property (p_ack_req) else $error("ack without request");
    property p_fall; $fell(req) |-> $past(ack); endproperty
    a_fall: assert property (p_fall) else $error("request dropped without ack");
    property p_gap; ack |=> !req; endproperty
    a_gap: assert property (p_gap) else $error("request kept after ack");
    property p_ack_rise; $rose(ack) |-> $past(req, 2) && $past(req); endproperty
    a_ack_rise: assert property (p_ack_rise) else $error("ack before request aged two cycles");

    cover property ($rose(req) && dir);
    cover property ($rose(req) && !dir);
    cover property ($rose(req) && be != 4'hF);
endmodule

// ### test/test_indirect_fabric_csr_access.sv
/*
 * Self-checking bench: APB master, fabric register storage, both ends joined.
 * Assumes the rtl folder is on the include path.
 */
`timescale 1ns/1ps
`include "ifca_map.svh"

module test_indirect_fabric_csr_access;
    import ifca_pkg::*;
    logic sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, csr_wdata, csr_rdata;
    logic pready, pslverr, csr_wr;
    logic [15:0] target_address;
    logic [31:0] mem [0:15];
    int n_fail = 0, checks_done = 0, cyc = 0;
    ifca_link_if lnk();
    ifca_bridge #(.APB_AW(12)) u_ifca_bridge (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link(lnk));
    ifca_fabric_end u_ifca_fabric_end (.sys_clk(sys_clk), .nrst(nrst), .link(lnk), .target_address(target_address),
        .csr_wdata(csr_wdata), .csr_wr(csr_wr), .csr_rdata(csr_rdata));
    ifca_link_checker u_ifca_link_checker (.sys_clk(sys_clk), .nrst(nrst), .req(lnk.req), .dir(lnk.dir),
        .addr(lnk.addr), .be(lnk.be), .wdata(lnk.wdata), .rdata(lnk.rdata), .ack(lnk.ack));

    always #50 sys_clk = ~sys_clk;
    // Sixteen words of storage are enough; upper address bits alias.
    assign csr_rdata = mem[target_address[3:0]];
    always @(posedge sys_clk) if (csr_wr) mem[target_address[3:0]] <= csr_wdata;

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One idle edge first, so release and the next setup never share a time step.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge sys_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask
    task automatic wait_idle();
        logic [31:0] q;
        int k;
        k = 0;
        do begin rd(`IFCA_CMD_OFS, q); k++; end while (q[31] !== 1'b0 && k < 20);
        chk("busy", q & 32'h80000000, 32'h0);
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] q;
        rd(`IFCA_DATA_OFS, q); chk("data rst", q, 32'h0);
        rd(`IFCA_CMD_OFS, q); chk("cmd rst", q, 32'h0);
    endtask
    task automatic t_lanes();
        logic [31:0] q, d, sh;
        sh = 32'hA5C30003;
        for (int i = 0; i < 16; i++) begin
            d = 32'h01010101 * (i + 1);
            wr(`IFCA_DATA_OFS, d);
            wr(`IFCA_CMD_OFS, {1'b1, 1'b0, 2'b00, 8'h00, 4'(i), 16'h0003});
            rd(`IFCA_CMD_OFS, q); chk("busy set", q & 32'h80000000, 32'h80000000);
            wait_idle();
            for (int n = 0; n < 4; n++) if (i[n]) sh[8*n +: 8] = d[8*n +: 8];
            chk("lane merge", mem[3], sh);
            rd(`IFCA_DATA_OFS, q); chk("write data back", q, d);
        end
    endtask
    task automatic t_read();
        logic [31:0] q;
        wr(`IFCA_CMD_OFS, 32'hC00F0005);
        wait_idle();
        rd(`IFCA_DATA_OFS, q); chk("fabric read", q, 32'hA5C30005);
        rd(`IFCA_CMD_OFS, q); chk("cmd after read", q, 32'h400F0005);
    endtask
    task automatic t_step_read(input logic [1:0] mode, input logic [15:0] dlt);
        logic [31:0] q;
        wr(`IFCA_CMD_OFS, {1'b1, 1'b1, mode, 8'h00, 4'hF, 16'h0008});
        wait_idle();
        rd(`IFCA_DATA_OFS, q); chk("step rd 1", q, 32'hA5C30008);
        wait_idle();
        rd(`IFCA_DATA_OFS, q); chk("step rd 2", q, {16'hA5C3, 16'h0008 + dlt});
        wait_idle();
        rd(`IFCA_CMD_OFS, q); chk("step rd addr", q, {2'b01, mode, 12'h00F, 16'(16'h0008 + 2 * dlt)});
        wr(`IFCA_CMD_OFS, 32'h0);
    endtask
    task automatic t_step_write(input logic [1:0] mode, input logic [15:0] dlt, input logic [31:0] d);
        logic [31:0] q;
        wr(`IFCA_CMD_OFS, {2'b00, mode, 8'h00, 4'hF, 16'h000C});
        wr(`IFCA_DATA_OFS, d);
        wait_idle();
        wr(`IFCA_DATA_OFS, ~d);
        wait_idle();
        chk("step wr 1", mem[12], d);
        chk("step wr 2", mem[4'(16'h000C + dlt)], ~d);
        rd(`IFCA_CMD_OFS, q); chk("step wr addr", q, {2'b00, mode, 12'h00F, 16'(16'h000C + 2 * dlt)});
        wr(`IFCA_CMD_OFS, 32'h0);
    endtask
    task automatic t_unmapped();
        logic [31:0] q;
        logic e;
        apb(1'b0, 12'h1B4, 32'h0, q, e);
        chk("unmapped err", 32'(e), 32'h1);
        chk("unmapped data", q, 32'h0);
        apb(1'b0, `IFCA_CMD_OFS, 32'h0, q, e);
        chk("mapped err", 32'(e), 32'h0);
    endtask
    // Registers loaded before a reset in mid-run must come back at their reset values.
    task automatic t_mid_reset();
        logic [31:0] q;
        wr(`IFCA_CMD_OFS, 32'h400F1234);
        rd(`IFCA_CMD_OFS, q); chk("cmd loaded", q, 32'h400F1234);
        wr(`IFCA_DATA_OFS, 32'h12345678);
        nrst <= 1'b0;
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        t_reset();
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end

    initial begin
        for (int i = 0; i < 16; i++) mem[i] = {16'hA5C3, 16'(i)};
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        t_reset();
        t_lanes();
        t_read();
        t_step_read(2'b10, 16'h0001);
        t_step_read(2'b01, 16'hFFFF);
        t_step_read(2'b11, 16'h0001);
        t_step_write(2'b10, 16'h0001, 32'h5A5A0F0F);
        t_step_write(2'b01, 16'hFFFF, 32'h3C3C9696);
        t_unmapped();
        t_mid_reset();
        give_verdict();
    end
endmodule
